//--- dbm_bank_match.sv
// Purpose: one bank's address window compare
// Assumes: start is a multiple of the span (software keeps that)
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module dbm_bank_match
(
   // Window
   input wire logic [7:0] start_i,
   input wire logic [8:0] span_i,
   input wire logic on_i,
   // Address
   input wire logic [7:0] addr_i,
   // Result
   output logic hit_o
);
   logic [8:0] off;
   // Span up to 256 units needs 9 bits so the top bank does not wrap
   assign off = {1'b0, addr_i} - {1'b0, start_i};
   assign hit_o = on_i && (addr_i >= start_i) && (off < span_i);
endmodule
`default_nettype wire

//--- dbm_dram_array.sv
// Purpose: far-side DRAM bank array driven by the bank strobes
// Assumes: strobes sampled on the controller clock
// Notes: counts strobed cycles and cycles with more than one strobe
`timescale 1ns/100ps
`default_nettype none
module dbm_dram_array
(
   // Clock
   input wire logic mclk_i,
   // Strobes
   input wire logic [3:0] bank_sel_i,
   // Observation
   output logic [15:0] clash_o,
   output logic [15:0] strobe_o
);
   logic [15:0] clash_r = 16'h0000;
   logic [15:0] strobe_r = 16'h0000;
   // any bank strobe; every strobed cycle is one array access
   always @(posedge mclk_i)
   begin
      if (bank_sel_i != 4'h0)
         strobe_r <= strobe_r + 16'h0001;
      if (!$onehot0(bank_sel_i))
         clash_r <= clash_r + 16'h0001;
   end
   assign clash_o = clash_r;
   assign strobe_o = strobe_r;
endmodule
`default_nettype wire

//--- dbm_pkg.sv
// Purpose: constants for the DRAM bank map and split remap block
// Assumes: 16-bit registers on a plain strobe port, 100 MHz clock
// Notes: addresses in the map are counted in 128 KB units (A24..A17)
package dbm_pkg;
   // Register offsets
   localparam logic [15:0] DBM_OFS_CONFIG = 16'h3872;
   localparam logic [15:0] DBM_OFS_START_A = 16'h4872;
   localparam logic [15:0] DBM_OFS_START_B = 16'h5072;
   localparam logic [15:0] DBM_OFS_SPLIT = 16'h5872;
   localparam logic [15:0] DBM_OFS_STATUS = 16'h5874;
   // Reset values
   localparam logic [15:0] DBM_RST_CONFIG = 16'h0000;
   localparam logic [15:0] DBM_RST_START = 16'h0000;
   localparam logic [15:0] DBM_RST_SPLIT = 16'h0000;
   // Config field positions
   localparam int DBM_PG_BIT = 11;
   localparam int DBM_ILV_LSB = 8;
   localparam int DBM_SIZE_W = 2;
   // Split register field positions
   localparam int DBM_EN_LSB = 12;
   localparam int DBM_DRV_LSB = 10;
   localparam int DBM_SPAN_LSB = 8;
   localparam int DBM_DEST_LSB = 2;
   // Split register bits that store a value (bits 1:0 are ignored)
   localparam logic [15:0] DBM_SPLIT_MASK = 16'hfffc;
   typedef enum logic [2:0] {
      DBM_ILV_NONE = 3'h0,
      DBM_ILV_01 = 3'h1,
      DBM_ILV_23 = 3'h2,
      DBM_ILV_BOTH = 3'h3,
      DBM_ILV_FOUR = 3'h4
   } dbm_ilv_type;
   // Split window base 0A0000H and limits, in 64 KB units (A23..A16)
   localparam logic [7:0] DBM_SPLIT_BASE = 8'h0a;
   localparam logic [7:0] DBM_SPLIT_TOP_1 = 8'h0d;
   localparam logic [7:0] DBM_SPLIT_TOP_2 = 8'h0e;
   localparam logic [7:0] DBM_SPLIT_TOP_3 = 8'h0f;
   // Bank span per device size code, in 128 KB units
   localparam logic [8:0] DBM_SPAN_64K = 9'h001;
   localparam logic [8:0] DBM_SPAN_256K = 9'h004;
   localparam logic [8:0] DBM_SPAN_1M = 9'h010;
   localparam logic [8:0] DBM_SPAN_4M = 9'h040;
   // Page size code: log2 of page bytes minus 9
   localparam logic [1:0] DBM_PAGE_SHIFT_BASE = 2'h0;
endpackage

//--- dbm_top.sv
// Purpose: DRAM bank map, interleave steering and split remap
// Assumes: registers on a strobe port, read data one cycle later
// Notes: decodes one CPU address per cycle into a bank select
// How it works
// - Interleave field picks none, pair 0/1, pair 2/3, both pairs, four-way.
// - Page select off alternates banks per word, on alternates per page.
// - Each bank has a 2-bit device size code, reset 00.
// - Every bank keeps its own size code, densities may be mixed.
// - Size code gives bank size 128K..8M and page size 512..4096 bytes.
// - Interleaved span is twice or four times the single bank size.
// - Start addresses are 8-bit A24..A17 fields, two per register.
// - Split register bits 15..12 enable banks 3..0, reset off.
// - Bits 11:10 select address drive strength, reset full.
// - Bits 9:8 select no split or 256, 320, 384 KB relocation.
// - Bits 7:2 give split destination A24..A19 on 512 KB boundary.
// - Bits 1:0 of the split register are ignored.
// - Page select resets to non-page mode.
`timescale 1ns/100ps
`default_nettype none
module dbm_top
   import dbm_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // CPU address A24..A1 of the current access
   input wire logic [24:1] cpu_addr_i,
   input wire logic cpu_req_i,
   // Bank selection
   output logic [3:0] bank_sel_o,
   output logic bank_hit_o,
   output logic [24:1] dram_addr_o,
   output logic [1:0] address_drive_strength_o,
   output logic page_mode_select_o,
   output logic [3:0] page_shift_o
);
   import dbm_pkg::*;

   logic [15:0] config_r;
   logic [15:0] start_a_r;
   logic [15:0] start_b_r;
   logic [15:0] split_r;
   logic [15:0] rdata_r;
   logic [3:0] sel_r;
   logic hit_r;
   logic [24:1] daddr_r;
   logic [3:0] pshift_r;

   // size code to span in 128 KB units
   function automatic logic [8:0] span_of(input logic [1:0] code);
      case (code)
         2'h0: span_of = DBM_SPAN_64K;
         2'h1: span_of = DBM_SPAN_256K;
         2'h2: span_of = DBM_SPAN_1M;
         default: span_of = DBM_SPAN_4M;
      endcase
   endfunction

   // size code field of one bank
   function automatic logic [1:0] size_of(input logic [15:0] cfg,
                                          input int bank);
      size_of = cfg[bank*DBM_SIZE_W +: DBM_SIZE_W];
   endfunction

   // Register writes
   always_ff @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         config_r <= DBM_RST_CONFIG;
         start_a_r <= DBM_RST_START;
         start_b_r <= DBM_RST_START;
         split_r <= DBM_RST_SPLIT;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            // each bank keeps its own code
            DBM_OFS_CONFIG: config_r <= reg_wdata_i;
            DBM_OFS_START_A: start_a_r <= reg_wdata_i;
            DBM_OFS_START_B: start_b_r <= reg_wdata_i;
            DBM_OFS_SPLIT: split_r <= reg_wdata_i & DBM_SPLIT_MASK;
            default: ;
         endcase
      end
   end

   dbm_ilv_type interleave_select;
   logic pg;
   logic [3:0] bank_on;
   logic [1:0] span_sel;
   logic [5:0] dest;
   logic [7:0] start [4];
   logic [8:0] span [4];
   logic [3:0] hit;

   assign interleave_select = dbm_ilv_type'(config_r[DBM_ILV_LSB +: 3]);
   assign pg = config_r[DBM_PG_BIT];
   assign bank_on = split_r[DBM_EN_LSB +: 4];
   assign span_sel = split_r[DBM_SPAN_LSB +: 2];
   assign dest = split_r[DBM_DEST_LSB +: 6];
   // bank 0 high byte of pair A, bank 2 low byte of pair B
   assign start[0] = start_a_r[15:8];
   assign start[1] = start_a_r[7:0];
   assign start[2] = start_b_r[7:0];
   assign start[3] = start_b_r[15:8];

   always_comb
   begin
      for (int b = 0; b < 4; b++)
         span[b] = span_of(size_of(config_r, b));
      case (interleave_select)
         DBM_ILV_01:
         begin
            span[0] = span[0] << 1;
            span[1] = span[1] << 1;
         end
         DBM_ILV_23:
         begin
            span[2] = span[2] << 1;
            span[3] = span[3] << 1;
         end
         DBM_ILV_BOTH:
         begin
            for (int b = 0; b < 4; b++)
               span[b] = span[b] << 1;
         end
         DBM_ILV_FOUR:
         begin
            for (int b = 0; b < 4; b++)
               span[b] = span[b] << 2;
         end
         default: ;
      endcase
   end

   // split relocation of the 0A0000H window
   logic [7:0] top64;
   logic in_split;
   logic [24:1] eff_addr;
   always_comb
   begin
      case (span_sel)
         2'h1: top64 = DBM_SPLIT_TOP_1;
         2'h2: top64 = DBM_SPLIT_TOP_2;
         default: top64 = DBM_SPLIT_TOP_3;
      endcase
      in_split = (span_sel != 2'h0) && (cpu_addr_i[24:20] == 5'h00)
                 && (cpu_addr_i[19:16] >= DBM_SPLIT_BASE[3:0])
                 && (cpu_addr_i[19:16] <= top64[3:0]);
      // Block offset from 0A0000H placed on a 512 KB destination
      eff_addr = cpu_addr_i;
      if (in_split)
         eff_addr = {dest, 18'h00000} +
                    {5'h00, cpu_addr_i[19:1] -
                     {DBM_SPLIT_BASE[3:0], 15'h0000}};
   end

   for (genvar g = 0; g < 4; g++)
   begin : g_match
      dbm_bank_match u_match
      (
         .start_i(start[g]),
         .span_i(span[g]),
         .on_i(bank_on[g]),
         .addr_i(eff_addr[24:17]),
         .hit_o(hit[g])
      );
   end

   // alternation bit: word bit A1 or the page bit above the page
   function automatic logic alt_bit(input logic [24:1] a,
                                    input logic [1:0] code,
                                    input logic page, input int step);
      logic [4:0] pos;
      pos = page ? 5'(9 + code + step) : 5'(1 + step);
      alt_bit = a[pos];
   endfunction

   logic [3:0] sel_nxt;
   logic [1:0] pcode;
   always_comb
   begin
      sel_nxt = 4'h0;
      pcode = size_of(config_r, 0);
      // Lowest hit wins; interleaved partners share a start so steer
      if (hit[0] || hit[1])
      begin
         pcode = hit[0] ? size_of(config_r, 0) : size_of(config_r, 1);
         if ((interleave_select == DBM_ILV_01 || interleave_select == DBM_ILV_BOTH) && hit[0] && hit[1])
            sel_nxt[alt_bit(eff_addr, pcode, pg, 0) ? 1 : 0] = 1'b1;
         else if (interleave_select == DBM_ILV_FOUR && hit[0])
            sel_nxt[{alt_bit(eff_addr, pcode, pg, 1),
                     alt_bit(eff_addr, pcode, pg, 0)}] = 1'b1;
         else
            sel_nxt = hit[0] ? 4'h1 : 4'h2;
      end
      else if (hit[2] || hit[3])
      begin
         pcode = hit[2] ? size_of(config_r, 2) : size_of(config_r, 3);
         if ((interleave_select == DBM_ILV_23 || interleave_select == DBM_ILV_BOTH) && hit[2] && hit[3])
            sel_nxt[alt_bit(eff_addr, pcode, pg, 0) ? 3 : 2] = 1'b1;
         else
            sel_nxt = hit[2] ? 4'h4 : 4'h8;
      end
      if (!cpu_req_i)
         sel_nxt = 4'h0;
   end

   // Registered decode result
   always_ff @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         sel_r <= 4'h0;
         hit_r <= 1'b0;
         daddr_r <= '0;
         pshift_r <= 4'h0;
      end
      else
      begin
         sel_r <= sel_nxt;
         hit_r <= |sel_nxt;
         daddr_r <= eff_addr;
         // page size is 512 bytes times two to the code
         pshift_r <= 4'(9) + {2'h0, pcode};
      end
   end

   // Register reads, answered one cycle after the strobe
   always_ff @(posedge mclk_i)
   begin
      if (!rstn_i)
         rdata_r <= 16'h0000;
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            DBM_OFS_CONFIG: rdata_r <= config_r;
            DBM_OFS_START_A: rdata_r <= start_a_r;
            DBM_OFS_START_B: rdata_r <= start_b_r;
            DBM_OFS_SPLIT: rdata_r <= split_r;
            DBM_OFS_STATUS: rdata_r <= {11'h000, hit_r, sel_r};
            default: rdata_r <= 16'h0000;
         endcase
      end
      else
         rdata_r <= 16'h0000;
   end

   assign reg_rdata_o = rdata_r;
   assign bank_sel_o = sel_r;
   assign bank_hit_o = hit_r;
   assign dram_addr_o = daddr_r;
   // drive strength straight from the field
   assign address_drive_strength_o = split_r[DBM_DRV_LSB +: 2];
   assign page_mode_select_o = pg;
   assign page_shift_o = pshift_r;

   // Checks
   property p_onehot;
      @(posedge mclk_i) disable iff (!rstn_i)
      $onehot0(sel_r);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("more than one bank selected");

   property p_enabled;
      @(posedge mclk_i) disable iff (!rstn_i)
      |sel_nxt |=> |(sel_r & $past(bank_on));
   endproperty
   a_enabled: assert property (p_enabled)
      else $error("disabled bank selected");

   property p_split_low;
      @(posedge mclk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == DBM_OFS_SPLIT |=> split_r[1:0] == 2'h0;
   endproperty
   a_split_low: assert property (p_split_low)
      else $error("ignored split bits stored");

   property p_drive;
      @(posedge mclk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == DBM_OFS_SPLIT |=>
         address_drive_strength_o == $past(reg_wdata_i[11:10]);
   endproperty
   a_drive: assert property (p_drive)
      else $error("drive strength not updated");

   property p_reset;
      @(posedge mclk_i) !rstn_i |=> config_r == 16'h0000 && !pg;
   endproperty
   a_reset: assert property (p_reset)
      else $error("config not cleared by reset");

   property p_nosplit;
      @(posedge mclk_i) disable iff (!rstn_i)
      span_sel == 2'h0 |-> eff_addr == cpu_addr_i;
   endproperty
   a_nosplit: assert property (p_nosplit)
      else $error("remap without split size");

   property p_dest;
      @(posedge mclk_i) disable iff (!rstn_i)
      in_split && cpu_addr_i[19:17] == 3'h5 |-> eff_addr[24:19] == dest;
   endproperty
   a_dest: assert property (p_dest)
      else $error("split base not at destination");

   property p_span4;
      @(posedge mclk_i) disable iff (!rstn_i)
      interleave_select == DBM_ILV_FOUR && config_r[1:0] == 2'h3 |-> span[0] == 9'h100;
   endproperty
   a_span4: assert property (p_span4)
      else $error("four-way span wrong");

   property p_size;
      @(posedge mclk_i) disable iff (!rstn_i)
      interleave_select == DBM_ILV_NONE && config_r[7:6] == 2'h2 |-> span[3] == 9'h010;
   endproperty
   a_size: assert property (p_size)
      else $error("bank size wrong");

   c_hit: cover property (@(posedge mclk_i) disable iff (!rstn_i) hit_r);
   c_pair: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      interleave_select == DBM_ILV_01 && sel_r[1]);
   c_four: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      interleave_select == DBM_ILV_FOUR && sel_r[3]);
   c_split: cover property (@(posedge mclk_i) disable iff (!rstn_i)
      in_split && |sel_nxt);
endmodule
`default_nettype wire

//--- testbench.sv
// Purpose: self-checking bench for the DRAM bank map block
// Assumes: register port with read data one cycle after the strobe
// Notes: four-way steering order is left open, only the hit and a one-hot select are checked
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dbm_pkg::*;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [24:1] cpu_addr_i = 24'h000000;
   logic cpu_req_i = 1'b0;
   logic [15:0] reg_rdata_o;
   logic [3:0] bank_sel_o;
   logic bank_hit_o;
   logic [24:1] dram_addr_o;
   logic [1:0] address_drive_strength_o;
   logic page_mode_select_o;
   logic [3:0] page_shift_o;
   logic [15:0] clash;
   logic [15:0] strobes;
   logic [1:0] sz [4];
   logic [7:0] st [4];
   logic [3:0] en;
   logic [2:0] interleave_select;
   logic pg;
   logic [15:0] v;
   logic [15:0] rb;
   logic [15:0] m;
   logic [24:0] ba;
   logic [24:0] top;
   logic [24:0] e;
   logic [15:0] regs [4];
   int err_total = 0;
   int checks = 0;

   always #5 mclk_i = ~mclk_i;

   dbm_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .cpu_addr_i(cpu_addr_i),
      .cpu_req_i(cpu_req_i), .bank_sel_o(bank_sel_o),
      .bank_hit_o(bank_hit_o), .dram_addr_o(dram_addr_o),
      .address_drive_strength_o(address_drive_strength_o),
      .page_mode_select_o(page_mode_select_o),
      .page_shift_o(page_shift_o));

   dbm_dram_array far (.mclk_i(mclk_i), .bank_sel_i(bank_sel_o),
      .clash_o(clash), .strobe_o(strobes));

   task chk(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task end_sim();
      $display("Checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask

   task rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(negedge mclk_i);
      d = reg_rdata_o;
   endtask

   task setup();
      wr(DBM_OFS_CONFIG, {4'h0, pg, interleave_select, sz[3], sz[2], sz[1], sz[0]});
      wr(DBM_OFS_START_A, {st[0], st[1]});
      wr(DBM_OFS_START_B, {st[3], st[2]});
      wr(DBM_OFS_SPLIT, {en, 12'h000});
   endtask

   // Lowest bank wins overlaps; pair members share size so sz[0] steers
   function automatic logic [3:0] exp_sel(input logic [24:0] a);
      int sp;
      int k;
      logic [3:0] r;
      r = 4'h0;
      for (int b = 3; b >= 0; b--)
      begin
         sp = 1 << (2 * sz[b]);
         if (interleave_select == DBM_ILV_FOUR)
            sp = sp * 4;
         else if (interleave_select != DBM_ILV_NONE &&
                  interleave_select != (b < 2 ? DBM_ILV_23 : DBM_ILV_01))
            sp = sp * 2;
         if (en[b] && a[24:17] >= st[b] && a[24:17] < st[b] + sp)
            r = 4'h1 << b;
      end
      k = pg ? 9 + sz[0] : 1;
      if (r[1:0] != 0 && (interleave_select == DBM_ILV_01 || interleave_select == DBM_ILV_BOTH))
         r = a[k] ? 4'h2 : 4'h1;
      if (r[3:2] != 0 && (interleave_select == DBM_ILV_23 || interleave_select == DBM_ILV_BOTH))
         r = a[k] ? 4'h8 : 4'h4;
      return r;
   endfunction

   task dec(input logic [24:0] a);
      @(posedge mclk_i);
      cpu_addr_i <= a[24:1];
      cpu_req_i <= 1'b1;
      @(posedge mclk_i);
      @(negedge mclk_i);
   endtask

   task chk_dec(input logic [24:0] a);
      logic [3:0] x;
      x = exp_sel(a);
      dec(a);
      chk("bank_sel", bank_sel_o, x);
      chk("bank_hit", bank_hit_o, |x);
      chk("dram_addr", dram_addr_o, a[24:1]);
      if (x != 4'h0)
         chk("page_shift", page_shift_o, 9 + sz[$clog2(x)]);
   endtask

   initial
   begin
      repeat (50000) @(posedge mclk_i);
      err_total++;
      end_sim();
   end

   initial
   begin
      regs = '{DBM_OFS_CONFIG, DBM_OFS_START_A, DBM_OFS_START_B,
               DBM_OFS_SPLIT};
      void'($urandom(32'h331a3e5d));
      repeat (6) @(posedge mclk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         rd(regs[i], rb);
         chk("reset_reg", rb, 16'h0000);
      end
      chk("drive", address_drive_strength_o, 2'h0);
      rd(16'h0000, rb);
      chk("unmapped", rb, 16'h0000);
      // Config bits above the page select are outside this block
      for (int i = 0; i < 12; i++)
      begin
         v = 16'($urandom);
         m = i % 4 == 0 ? 16'h0fff : 16'hffff;
         wr(regs[i % 4], v);
         rd(regs[i % 4], rb);
         chk("readback", rb & m, v & m & (i % 4 == 3 ? 16'hfffc : m));
         if (i % 4 == 0)
            chk("page_mode", page_mode_select_o, v[11]);
      end
      for (int d = 0; d < 4; d++)
      begin
         wr(DBM_OFS_SPLIT, 16'(d << DBM_DRV_LSB));
         @(negedge mclk_i);
         chk("drive", address_drive_strength_o, d[1:0]);
      end
      // mixed sizes, aligned, smaller banks higher
      interleave_select = DBM_ILV_NONE;
      pg = 1'b0;
      sz = '{2'h3, 2'h2, 2'h1, 2'h0};
      st = '{8'h00, 8'h40, 8'h50, 8'h54};
      en = 4'hf;
      setup();
      foreach (st[i])
      begin
         chk_dec({st[i], 17'($urandom)});
         chk_dec({st[i] - 8'h01, 17'h1fffe});
      end
      chk_dec({8'h55, 17'h00000});
      for (int i = 0; i < 30; i++)
         chk_dec({8'($urandom_range(8'h5f)), 17'($urandom)});
      en = 4'hb;
      setup();
      chk_dec({8'h51, 17'h00000});
      @(posedge mclk_i);
      cpu_req_i <= 1'b0;
      @(posedge mclk_i);
      @(negedge mclk_i);
      chk("idle_sel", bank_sel_o, 4'h0);
      // equal 256K pairs, enabled, common start
      sz = '{4{2'h1}};
      en = 4'hf;
      for (int k = 1; k < 7; k++)
      begin
         interleave_select = 3'(k / 2 + k % 2);
         pg = 1'(k % 2 == 0);
         st[0] = interleave_select == DBM_ILV_23 ? 8'h08 : 8'h00;
         st[1] = interleave_select == DBM_ILV_23 ? 8'h0c : 8'h00;
         st[2] = interleave_select == DBM_ILV_23 ? 8'h00 : 8'h08;
         st[3] = interleave_select == DBM_ILV_01 ? 8'h0c : st[2];
         setup();
         chk("page_mode", page_mode_select_o, pg);
         for (int i = 0; i < 16; i++)
            chk_dec({8'($urandom_range(8'h10)), 17'($urandom)});
      end
      // four-way only in page mode with 4M devices
      interleave_select = DBM_ILV_FOUR;
      pg = 1'b1;
      sz = '{4{2'h3}};
      st = '{4{8'h00}};
      setup();
      for (int i = 0; i < 12; i++)
      begin
         dec({8'($urandom), 17'($urandom)});
         chk("four_hit", bank_hit_o, 1'b1);
         chk("four_sel", $onehot(bank_sel_o), 1'b1);
      end
      // Address and request still stand, so status shows the last hit
      rd(DBM_OFS_STATUS, rb);
      chk("status_hit", rb[4], 1'b1);
      chk("status_sel", $onehot(rb[3:0]), 1'b1);
      // split remap to 280000H with all banks enabled, sizes from the four-way setup
      for (int s = 1; s < 4; s++)
      begin
         v = {4'hf, 2'h0, 2'(s), 6'h05, 2'h3};
         wr(DBM_OFS_SPLIT, v);
         rd(DBM_OFS_SPLIT, rb);
         chk("split_low", rb, v & DBM_SPLIT_MASK);
         top = 25'h0dffff + 25'h10000 * 25'(s - 1);
         for (int j = 0; j < 8; j++)
         begin
            ba = j == 0 ? 25'h0a0000 : j == 1 ? top - 25'h1 :
                 j == 2 ? top + 25'h1 : j == 3 ? 25'h09fffe :
                 25'h0a0000 + 25'({$urandom_range(32'h1ffff), 1'b0});
            dec(ba);
            e = ba >= 25'h0a0000 && ba <= top ?
                25'h280000 + ba - 25'h0a0000 : ba;
            chk("split_addr", dram_addr_o, e[24:1]);
         end
      end
      // Reset in mid-run clears the map again
      @(posedge mclk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rd(DBM_OFS_SPLIT, rb);
      chk("rerun_split", rb, 16'h0000);
      rd(DBM_OFS_CONFIG, rb);
      chk("rerun_config", rb, 16'h0000);
      chk("rerun_sel", bank_sel_o, 4'h0);
      chk("clash", clash, 16'h0000);
      chk("strobes", strobes != 16'h0000, 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire
